// ### shared/boot_pkg.sv
// Notes on behaviour
// - checksum reply: 18h rx error, 11h bad, 10h good
// - reception off; time first four first-byte edges
// - async when first interval not above third-fourth
// - uniform non-blank password area forces 11h
// - all twelve password bytes must match
// - received bytes one to twelve against 474h..47Fh
// - 16-bit flash sum, high byte first
// - checksum is two's complement of byte sum
// - ack: command nibble, bit3 rx, bit0 bad
// - no reception error check in clocked mode
// - unusable baud rate: stop silently
// - mode byte ack 86h async, 30h clocked
package boot_pkg;
  localparam logic [7:0]  ACK_MODE_ASYNC   = 8'h86;
  localparam logic [7:0]  ACK_MODE_CLOCKED = 8'h30;
  localparam logic [7:0]  CMD_RAM_XFER     = 8'h10;
  localparam logic [7:0]  CMD_FLASH_SUM    = 8'h20;
  localparam logic [7:0]  CMD_PROD_INFO    = 8'h30;
  localparam logic [7:0]  ACK_CKS_OK       = 8'h10;
  localparam logic [7:0]  ACK_CKS_BAD      = 8'h11;
  localparam logic [7:0]  ACK_CKS_RXERR    = 8'h18;
  localparam logic [3:0]  ACK_LOW_RXERR    = 4'h8;
  localparam logic [3:0]  ACK_LOW_BAD      = 4'h1;
  localparam logic [7:0]  PW_BLANK         = 8'hff;
  localparam int          PW_LEN           = 12;
  localparam int          FLASH_ADDR_W     = 19;
  localparam int          FLASH_BYTES_DEF  = 524288;
  localparam logic [18:0] PW_BASE          = 19'h00474;
  localparam int          TIMER_W          = 24;
  localparam logic [2:0]  EDGES_NEEDED     = 3'h4;

  typedef enum logic [9:0] {
    S_DETECT  = 10'h001,
    S_HALT    = 10'h002,
    S_MODEACK = 10'h004,
    S_CMD     = 10'h008,
    S_ECHO    = 10'h010,
    S_PWREAD  = 10'h020,
    S_PWRX    = 10'h040,
    S_SUM     = 10'h080,
    S_SUMHI   = 10'h100,
    S_SUMLO   = 10'h200
  } boot_state_e;
endpackage : boot_pkg

// ### logic/boot_loader.sv
`timescale 1ns/1ps
`default_nettype none
module boot_loader #(
  parameter int FLASH_BYTES = boot_pkg::FLASH_BYTES_DEF
) (
  // clock and reset
  input  wire logic                              clk_sys,
  input  wire logic                              srst,
  // receive pin, watched for mode detection
  input  wire logic                              rxd_pin,
  // received bytes from the boot serial channel
  input  wire logic                              rx_valid,
  input  wire logic [7:0]                        rx_data,
  input  wire logic                              rx_err,
  input  wire logic                              baud_ok,
  // channel control
  output logic                                   rx_enable,
  output logic                                   mode_async,
  output logic [boot_pkg::TIMER_W-1:0]           bit_time,
  output logic                                   halted,
  // bytes to transmit
  output logic                                   tx_valid,
  output logic [7:0]                             tx_data,
  input  wire logic                              tx_ready,
  // flash read port, data one cycle after the strobe
  output logic                                   flash_rd,
  output logic [boot_pkg::FLASH_ADDR_W-1:0]      flash_addr,
  input  wire logic [7:0]                        flash_rdata
);
  import boot_pkg::*;

  // ----------------------------------------
  // pin sampling and edge timing
  // ----------------------------------------
  logic               sy1_ff, sy2_ff, sy3_ff, lvl_ff, nxt_lvl;
  logic [TIMER_W-1:0] tmr_ff, nxt_tmr, ta_ff, nxt_ta, tb_ff, nxt_tb, tc_ff, nxt_tc;
  logic [TIMER_W-1:0] t_ab, t_cd;
  logic [2:0]         edg_ff, nxt_edg;
  logic               edge_w, det_done;
  boot_state_e        state_ff, nxt_state, ret_ff, nxt_ret;

  always_comb begin
    nxt_tmr  = tmr_ff + 1'b1;
    nxt_lvl  = lvl_ff;
    nxt_edg  = edg_ff;
    nxt_ta   = ta_ff;
    nxt_tb   = tb_ff;
    nxt_tc   = tc_ff;
    t_ab     = tb_ff - ta_ff;
    t_cd     = tmr_ff - tc_ff;
    edge_w   = (sy2_ff == sy3_ff) && (sy3_ff != lvl_ff);
    det_done = 1'b0;
    if (edge_w) begin
      nxt_lvl = sy3_ff;
    end
    if (state_ff == S_DETECT && edge_w) begin
      nxt_edg = edg_ff + 3'h1;
      case (edg_ff)
        3'h0:    nxt_ta = tmr_ff;
        3'h1:    nxt_tb = tmr_ff;
        3'h2:    nxt_tc = tmr_ff;
        default: det_done = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    sy1_ff <= rxd_pin;
    sy2_ff <= sy1_ff;
    sy3_ff <= sy2_ff;
    if (srst) begin
      lvl_ff <= 1'b1;
      tmr_ff <= '0;
      edg_ff <= '0;
      ta_ff  <= '0;
      tb_ff  <= '0;
      tc_ff  <= '0;
    end else begin
      lvl_ff <= nxt_lvl;
      tmr_ff <= nxt_tmr;
      edg_ff <= nxt_edg;
      ta_ff  <= nxt_ta;
      tb_ff  <= nxt_tb;
      tc_ff  <= nxt_tc;
    end
  end

  // ----------------------------------------
  // protocol sequencer
  // ----------------------------------------
  logic [7:0]         txb_ff, nxt_txb, sck_ff, nxt_sck;
  logic [3:0]         nib_ff, nxt_nib, rxc_ff, nxt_rxc;
  logic [15:0]        sum_ff, nxt_sum;
  logic [19:0]        idx_ff, nxt_idx;
  logic               pend_ff, nxt_pend, bad_ff, nxt_bad, rxe_ff, nxt_rxe, area_ff, nxt_area;
  logic               async_ff, nxt_async, halt_ff, nxt_halt, rxen_ff, nxt_rxen;
  logic [TIMER_W-1:0] bt_ff, nxt_bt;
  logic [FLASH_ADDR_W-1:0] fa_ff, nxt_fa;
  logic               frd_ff, nxt_frd;
  logic [7:0]         pw_ff [PW_LEN];
  logic [7:0]         nxt_pw [PW_LEN];
  logic               buf_push, in_ready, same_w, rx_bad_w;
  logic [7:0]         push_data, sck_fin;
  logic [19:0]        limit_w;

  always_comb begin
    nxt_state = state_ff;
    nxt_ret   = ret_ff;
    nxt_txb   = txb_ff;
    nxt_sck   = sck_ff;
    nxt_nib   = nib_ff;
    nxt_rxc   = rxc_ff;
    nxt_sum   = sum_ff;
    nxt_idx   = idx_ff;
    nxt_bad   = bad_ff;
    nxt_rxe   = rxe_ff;
    nxt_area  = area_ff;
    nxt_async = async_ff;
    nxt_halt  = halt_ff;
    nxt_rxen  = rxen_ff;
    nxt_bt    = bt_ff;
    nxt_fa    = fa_ff;
    nxt_frd   = 1'b0;
    nxt_pw    = pw_ff;
    nxt_pend  = frd_ff;
    buf_push  = 1'b0;
    push_data = txb_ff;
    same_w    = 1'b1;
    rx_bad_w  = async_ff && rx_err;
    sck_fin   = sck_ff + rx_data;
    limit_w   = (state_ff == S_PWREAD) ? 20'(PW_LEN) : 20'(FLASH_BYTES);
    for (int i = 1; i < PW_LEN; i++) begin
      if (pw_ff[i] != pw_ff[0]) same_w = 1'b0;
    end
    unique case (state_ff)
      S_DETECT: if (det_done) begin
        nxt_async = (t_ab <= t_cd);
        nxt_bt    = t_ab >> 1;
        if (t_ab <= t_cd && !baud_ok) begin
          nxt_state = S_HALT;
          nxt_halt  = 1'b1;
        end else begin
          nxt_state = S_MODEACK;
          nxt_rxen  = 1'b1;
        end
      end
      S_HALT: nxt_state = S_HALT;
      S_MODEACK: begin
        buf_push  = in_ready;
        push_data = async_ff ? ACK_MODE_ASYNC : ACK_MODE_CLOCKED;
        if (in_ready) nxt_state = S_CMD;
      end
      S_CMD: if (rx_valid) begin
        nxt_state = S_ECHO;
        nxt_ret   = S_CMD;
        nxt_idx   = '0;
        nxt_sum   = '0;
        if (rx_bad_w) begin
          nxt_txb = {nib_ff, ACK_LOW_RXERR};
        end else if (rx_data == CMD_RAM_XFER || rx_data == CMD_FLASH_SUM ||
                     rx_data == CMD_PROD_INFO) begin
          nxt_txb = rx_data;
          nxt_nib = rx_data[7:4];
          if (rx_data == CMD_RAM_XFER) nxt_ret = S_PWREAD;
          if (rx_data == CMD_FLASH_SUM) nxt_ret = S_SUM;
        end else begin
          nxt_txb = {nib_ff, ACK_LOW_BAD};
        end
      end
      S_ECHO: begin
        buf_push = in_ready;
        if (in_ready) nxt_state = ret_ff;
      end
      S_PWREAD, S_SUM: begin
        if (idx_ff < limit_w && !frd_ff) begin
          nxt_frd = 1'b1;
          nxt_fa  = (state_ff == S_PWREAD) ? PW_BASE + idx_ff[FLASH_ADDR_W-1:0]
                                           : idx_ff[FLASH_ADDR_W-1:0];
          nxt_idx = idx_ff + 20'h1;
        end
        if (pend_ff) begin
          if (state_ff == S_PWREAD) nxt_pw[idx_ff[3:0] - 4'h1] = flash_rdata;
          else nxt_sum = sum_ff + {8'h00, flash_rdata};
        end
        if (idx_ff == limit_w && !frd_ff && !pend_ff) begin
          if (state_ff == S_PWREAD) begin
            nxt_state = S_PWRX;
            nxt_area  = same_w && pw_ff[0] != PW_BLANK;
            nxt_rxc   = '0;
            nxt_bad   = 1'b0;
            nxt_rxe   = 1'b0;
            nxt_sck   = '0;
          end else begin
            nxt_state = S_SUMHI;
          end
        end
      end
      S_PWRX: if (rx_valid) begin
        nxt_rxc = rxc_ff + 4'h1;
        nxt_sck = sck_fin;
        nxt_rxe = rxe_ff || rx_bad_w;
        if (rxc_ff < 4'(PW_LEN) && rx_data != pw_ff[rxc_ff]) nxt_bad = 1'b1;
        if (rxc_ff == 4'(PW_LEN)) begin
          nxt_state = S_ECHO;
          nxt_ret   = S_CMD;
          if (rxe_ff || rx_bad_w) nxt_txb = ACK_CKS_RXERR;
          else if (bad_ff || area_ff || sck_fin != 8'h00) nxt_txb = ACK_CKS_BAD;
          else nxt_txb = ACK_CKS_OK;
        end
      end
      S_SUMHI: begin
        buf_push  = in_ready;
        push_data = sum_ff[15:8];
        if (in_ready) nxt_state = S_SUMLO;
      end
      S_SUMLO: begin
        buf_push  = in_ready;
        push_data = sum_ff[7:0];
        nxt_txb   = 8'h00 - (sum_ff[15:8] + sum_ff[7:0]);
        nxt_ret   = S_CMD;
        if (in_ready) nxt_state = S_ECHO;
      end
      default: nxt_state = S_HALT;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_ff <= S_DETECT;
      ret_ff   <= S_CMD;
      txb_ff   <= '0;
      sck_ff   <= '0;
      nib_ff   <= '0;
      rxc_ff   <= '0;
      sum_ff   <= '0;
      idx_ff   <= '0;
      pend_ff  <= 1'b0;
      bad_ff   <= 1'b0;
      rxe_ff   <= 1'b0;
      area_ff  <= 1'b0;
      async_ff <= 1'b0;
      halt_ff  <= 1'b0;
      rxen_ff  <= 1'b0;
      bt_ff    <= '0;
      fa_ff    <= '0;
      frd_ff   <= 1'b0;
      for (int i = 0; i < PW_LEN; i++) pw_ff[i] <= '0;
    end else begin
      state_ff <= nxt_state;
      ret_ff   <= nxt_ret;
      txb_ff   <= nxt_txb;
      sck_ff   <= nxt_sck;
      nib_ff   <= nxt_nib;
      rxc_ff   <= nxt_rxc;
      sum_ff   <= nxt_sum;
      idx_ff   <= nxt_idx;
      pend_ff  <= nxt_pend;
      bad_ff   <= nxt_bad;
      rxe_ff   <= nxt_rxe;
      area_ff  <= nxt_area;
      async_ff <= nxt_async;
      halt_ff  <= nxt_halt;
      rxen_ff  <= nxt_rxen;
      bt_ff    <= nxt_bt;
      fa_ff    <= nxt_fa;
      frd_ff   <= nxt_frd;
      pw_ff    <= nxt_pw;
    end
  end

  // ----------------------------------------
  // two-entry transmit buffer
  // ----------------------------------------
  // skid register keeps a byte when the channel stalls; the sequencer
  // waits while it is occupied, so no reply is ever dropped
  logic       ov_ff, nxt_ov, sv_ff, nxt_sv;
  logic [7:0] od_ff, nxt_od, sd_ff, nxt_sd;

  always_comb begin
    in_ready = !sv_ff;
    nxt_ov   = ov_ff;
    nxt_od   = od_ff;
    nxt_sv   = sv_ff;
    nxt_sd   = sd_ff;
    if (ov_ff && tx_ready) begin
      if (sv_ff) begin
        nxt_od = sd_ff;
        nxt_sv = 1'b0;
      end else begin
        nxt_ov = buf_push;
        nxt_od = push_data;
      end
    end else if (buf_push) begin
      if (!ov_ff) begin
        nxt_ov = 1'b1;
        nxt_od = push_data;
      end else begin
        nxt_sv = 1'b1;
        nxt_sd = push_data;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ov_ff <= 1'b0;
      sv_ff <= 1'b0;
      od_ff <= '0;
      sd_ff <= '0;
    end else begin
      ov_ff <= nxt_ov;
      sv_ff <= nxt_sv;
      od_ff <= nxt_od;
      sd_ff <= nxt_sd;
    end
  end

  assign tx_valid   = ov_ff;
  assign tx_data    = od_ff;
  assign rx_enable  = rxen_ff;
  assign mode_async = async_ff;
  assign bit_time   = bt_ff;
  assign halted     = halt_ff;
  assign flash_rd   = frd_ff;
  assign flash_addr = fa_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_hi_sent;
    state_ff == S_SUMHI && buf_push;
  endsequence
  property p_rx_off;
    @(posedge clk_sys) disable iff (srst) state_ff == S_DETECT |-> !rxen_ff;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("reception on during detection");
  property p_mode;
    @(posedge clk_sys) disable iff (srst) det_done |=> async_ff == ($past(t_ab) <= $past(t_cd));
  endproperty
  a_mode: assert property (p_mode) else $error("wrong mode chosen");
  property p_halt;
    @(posedge clk_sys) disable iff (srst) state_ff == S_HALT |-> !buf_push ##1 state_ff == S_HALT;
  endproperty
  a_halt: assert property (p_halt) else $error("halted block answered");
  property p_mode_ack;
    @(posedge clk_sys) disable iff (srst)
      state_ff == S_MODEACK && buf_push |=> od_ff == (async_ff ? ACK_MODE_ASYNC : ACK_MODE_CLOCKED) || sv_ff;
  endproperty
  a_mode_ack: assert property (p_mode_ack) else $error("bad mode ack");
  property p_ack_zero;
    @(posedge clk_sys) disable iff (srst)
      (state_ff == S_CMD || state_ff == S_PWRX) && nxt_state == S_ECHO |=>
        txb_ff[2:1] == 2'b00 && txb_ff[7:4] == nib_ff;
  endproperty
  a_ack_zero: assert property (p_ack_zero) else $error("ack bits 2:1 set");
  property p_clk_noerr;
    @(posedge clk_sys) disable iff (srst)
      state_ff == S_CMD && rx_valid && !async_ff |=> !txb_ff[3];
  endproperty
  a_clk_noerr: assert property (p_clk_noerr) else $error("rx error in clocked mode");
  property p_area;
    @(posedge clk_sys) disable iff (srst)
      state_ff == S_PWRX && rx_valid && rxc_ff == 4'(PW_LEN) && area_ff && !(rxe_ff || rx_bad_w)
        |=> txb_ff == ACK_CKS_BAD;
  endproperty
  a_area: assert property (p_area) else $error("password area error missed");
  property p_pw_addr;
    @(posedge clk_sys) disable iff (srst)
      frd_ff && state_ff == S_PWREAD |-> fa_ff >= 19'h00474 && fa_ff <= 19'h0047f;
  endproperty
  a_pw_addr: assert property (p_pw_addr) else $error("password read outside area");
  property p_sum_order;
    @(posedge clk_sys) disable iff (srst) s_hi_sent |-> push_data == sum_ff[15:8] ##1 state_ff == S_SUMLO;
  endproperty
  a_sum_order: assert property (p_sum_order) else $error("sum byte order wrong");
  property p_cks;
    @(posedge clk_sys) disable iff (srst)
      state_ff == S_SUMLO && buf_push |=> 8'(txb_ff + sum_ff[15:8] + sum_ff[7:0]) == 8'h00;
  endproperty
  a_cks: assert property (p_cks) else $error("checksum wrong");
endmodule : boot_loader
`default_nettype wire

// ### bench/prog_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module prog_ctrl_model (
  // clock
  input  wire logic       clk_sys,
  // link toward the device
  output logic            rxd_pin,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_err,
  // bytes coming back
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [7:0] got_q[$];
  logic       stall;

  initial begin
    rxd_pin  = 1'b1;
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_err   = 1'b0;
    tx_ready = 1'b0;
    stall    = 1'b0;
  end

  // --------------------------------------------------------------------------
  // reply collection
  // --------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    tx_ready <= ~stall;
    if (tx_valid && tx_ready) begin
      got_q.push_back(tx_data);
    end
  end

  // --------------------------------------------------------------------------
  // link tasks
  // --------------------------------------------------------------------------
  // start bit, data lsb first, stop bit; line idles high afterwards
  task automatic send_mode(input logic [7:0] b, input int bit_cyc);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      rxd_pin <= frame[i];
      repeat (bit_cyc) @(posedge clk_sys);
    end
  endtask : send_mode

  task automatic send_byte(input logic [7:0] b, input logic err);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_data  <= b;
    rx_err   <= err;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_err   <= 1'b0;
    rx_data  <= ~b;
  endtask : send_byte

  // a controller gives up rather than wait forever for an answer
  task automatic get_byte(output logic [7:0] b);
    b = 8'hxx;
    for (int i = 0; i < 600 && got_q.size() == 0; i++) @(posedge clk_sys);
    if (got_q.size() != 0) b = got_q.pop_front();
  endtask : get_byte

  function automatic logic [7:0] cks(input logic [7:0] sum);
    return 8'h00 - sum;
  endfunction : cks
endmodule : prog_ctrl_model
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module tb;
  import boot_pkg::*;
  logic                    clk_sys = 1'b0;
  logic                    srst = 1'b1;
  logic                    baud_ok = 1'b1;
  logic                    rxd_pin, rx_valid, rx_err, tx_ready;
  logic [7:0]              rx_data, tx_data;
  logic                    rx_enable, mode_async, halted, tx_valid, flash_rd;
  logic [TIMER_W-1:0]      bit_time;
  logic [FLASH_ADDR_W-1:0] flash_addr;
  logic [7:0]              flash_rdata = 8'h00;
  logic [7:0]              mem [0:2047];
  int                      miscompares = 0;
  int                      tests_run = 0;
  int                      cyc = 0;

  always #4 clk_sys = ~clk_sys;

  boot_loader #(.FLASH_BYTES(4)) boot_loader_i (
    .clk_sys(clk_sys), .srst(srst), .rxd_pin(rxd_pin), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_err(rx_err), .baud_ok(baud_ok), .rx_enable(rx_enable), .mode_async(mode_async),
    .bit_time(bit_time), .halted(halted), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_rdata(flash_rdata));

  prog_ctrl_model prog_ctrl_model_i (
    .clk_sys(clk_sys), .rxd_pin(rxd_pin), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_err(rx_err), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

  // --------------------------------------------------------------------------
  // flash model: data valid only in the cycle after the strobe
  // --------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    flash_rdata <= flash_rd ? mem[flash_addr[10:0]] : ~flash_rdata;
  end

  // --------------------------------------------------------------------------
  // helpers and scenarios
  // --------------------------------------------------------------------------
  task automatic do_reset();
    srst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
  endtask : do_reset

  task automatic expect_tx(input logic [7:0] exp);
    logic [7:0] b;
    prog_ctrl_model_i.get_byte(b);
    `CHK(b, exp)
  endtask : expect_tx

  task automatic t_halt();
    do_reset();
    baud_ok <= 1'b0;
    prog_ctrl_model_i.send_mode(8'h86, 20);
    repeat (8) @(posedge clk_sys);
    `CHK(halted, 1'b1)
    `CHK(rx_enable, 1'b0)
    repeat (100) @(posedge clk_sys);
    `CHK(prog_ctrl_model_i.got_q.size(), 0)
    baud_ok <= 1'b1;
  endtask : t_halt

  // 30h has a long first interval, so the clocked reading wins
  task automatic t_clocked();
    do_reset();
    prog_ctrl_model_i.send_mode(8'h30, 20);
    repeat (8) @(posedge clk_sys);
    `CHK(mode_async, 1'b0)
    expect_tx(ACK_MODE_CLOCKED);
    prog_ctrl_model_i.send_byte(CMD_PROD_INFO, 1'b1);
    expect_tx(CMD_PROD_INFO);
    prog_ctrl_model_i.send_byte(8'h55, 1'b0);
    expect_tx(8'h31);
  endtask : t_clocked

  task automatic t_async();
    do_reset();
    `CHK(rx_enable, 1'b0)
    prog_ctrl_model_i.send_mode(8'h86, 20);
    repeat (8) @(posedge clk_sys);
    `CHK(mode_async, 1'b1)
    `CHK(rx_enable, 1'b1)
    `CHK(bit_time, 24'h000014)
    expect_tx(ACK_MODE_ASYNC);
    prog_ctrl_model_i.send_byte(8'h55, 1'b0);
    expect_tx(8'h01);
    prog_ctrl_model_i.send_byte(CMD_PROD_INFO, 1'b1);
    expect_tx(8'h08);
  endtask : t_async

  // replies pile up behind a stalled receiver and must all arrive in order
  task automatic t_sum();
    prog_ctrl_model_i.stall <= 1'b1;
    prog_ctrl_model_i.send_byte(CMD_FLASH_SUM, 1'b0);
    repeat (40) @(posedge clk_sys);
    prog_ctrl_model_i.stall <= 1'b0;
    expect_tx(CMD_FLASH_SUM);
    expect_tx(8'h02);
    expect_tx(8'hea);
    expect_tx(8'h14);
    prog_ctrl_model_i.send_byte(8'h77, 1'b0);
    expect_tx(8'h21);
  endtask : t_sum

  task automatic pw_run(input logic [7:0] flip, input logic err, input logic [7:0] exp);
    logic [7:0] b;
    logic [7:0] sum;
    sum = 8'h00;
    prog_ctrl_model_i.send_byte(CMD_RAM_XFER, 1'b0);
    expect_tx(CMD_RAM_XFER);
    repeat (40) @(posedge clk_sys);
    for (int i = 0; i < PW_LEN; i++) begin
      b = mem[11'h474 + 11'(i)] ^ ((i == PW_LEN - 1) ? flip : 8'h00);
      sum = sum + b;
      prog_ctrl_model_i.send_byte(b, err && (i == 5));
    end
    prog_ctrl_model_i.send_byte(prog_ctrl_model_i.cks(sum), 1'b0);
    expect_tx(exp);
  endtask : pw_run

  task automatic t_password();
    pw_run(8'h00, 1'b0, ACK_CKS_OK);
    pw_run(8'h01, 1'b0, ACK_CKS_BAD);
    pw_run(8'h00, 1'b1, ACK_CKS_RXERR);
    for (int i = 0; i < PW_LEN; i++) mem[11'h474 + 11'(i)] = 8'h5a;
    pw_run(8'h00, 1'b0, ACK_CKS_BAD);
  endtask : t_password

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  // --------------------------------------------------------------------------
  // main sequence and hang guard
  // --------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    for (int i = 0; i < 2048; i++) mem[i] = 8'hff;
    mem[0] = 8'ha1;
    mem[1] = 8'hb2;
    mem[2] = 8'hc3;
    mem[3] = 8'hd4;
    for (int i = 0; i < PW_LEN; i++) mem[11'h474 + 11'(i)] = 8'h31 + 8'(i);
    t_halt();
    t_clocked();
    t_async();
    t_sum();
    t_password();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
